// file: rtl/dcm_pkg.sv
`default_nettype none
package dcm_pkg;

  // task file offsets on the command block port
  localparam logic [2:0] ADDR_DATA    = 3'h0;
  localparam logic [2:0] ADDR_FEATURE = 3'h1;
  localparam logic [2:0] ADDR_SEC_CNT = 3'h2;
  localparam logic [2:0] ADDR_SEC_NUM = 3'h3;
  localparam logic [2:0] ADDR_CYL_LO  = 3'h4;
  localparam logic [2:0] ADDR_CYL_HI  = 3'h5;
  localparam logic [2:0] ADDR_DEV_HD  = 3'h6;
  localparam logic [2:0] ADDR_CMD     = 3'h7;

  // opcodes and monitoring keys
  localparam logic [7:0] OP_SET_MULT  = 8'hC6;
  localparam logic [7:0] OP_SLEEP     = 8'hE6;
  localparam logic [7:0] OP_SLEEP_ALT = 8'h99;
  localparam logic [7:0] OP_SMART     = 8'hB0;
  localparam logic [7:0] SMART_KEY_LO = 8'h4F;
  localparam logic [7:0] SMART_KEY_HI = 8'hC2;

  // monitoring subcommand codes
  localparam logic [7:0] SUB_READ_ATTR  = 8'hD0;
  localparam logic [7:0] SUB_READ_THR   = 8'hD1;
  localparam logic [7:0] SUB_AUTOSAVE   = 8'hD2;
  localparam logic [7:0] SUB_SAVE_ATTR  = 8'hD3;
  localparam logic [7:0] SUB_OFFLINE    = 8'hD4;
  localparam logic [7:0] SUB_READ_LOG   = 8'hD5;
  localparam logic [7:0] SUB_WRITE_LOG  = 8'hD6;
  localparam logic [7:0] SUB_ENABLE     = 8'hD8;
  localparam logic [7:0] SUB_DISABLE    = 8'hD9;
  localparam logic [7:0] SUB_STATUS     = 8'hDA;
  localparam logic [7:0] SUB_AUTO_OFFLN = 8'hDB;

  // largest legal multiple block size
  localparam logic [7:0] BSIZE_MAX = 8'h10;

  // status and error bit positions
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DF  = 5;
  localparam int ST_DSC = 4;
  localparam int ST_COR = 2;
  localparam int ST_ERR = 0;
  localparam int ER_ABT = 2;

  // reset, busy and completion values
  localparam logic [7:0] STATUS_READY = 8'h50;
  localparam logic [7:0] STATUS_BUSY  = 8'h80;
  localparam logic [7:0] STATUS_ABORT = 8'h51;
  localparam logic [7:0] ERROR_NONE   = 8'h00;
  localparam logic [7:0] ERROR_ABORT  = 8'h04;

  typedef enum logic [1:0] {
    DCM_IDLE   = 2'b00,
    DCM_BUSY   = 2'b01,
    DCM_SPIN   = 2'b10,
    DCM_ASLEEP = 2'b11
  } dcm_state_e;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
    logic [7:0] count;
    logic [7:0] number;
  } dcm_smart_s;

  typedef struct packed {
    logic is_set_mult;
    logic bsize_ok;
    logic is_sleep;
    logic is_smart;
    logic keys_ok;
    logic sub_ok;
  } dcm_decode_s;

  typedef struct packed {
    logic meta;
    logic stable;
  } dcm_sync_s;

  typedef struct packed {
    dcm_state_e st;
    logic [7:0] feature;
    logic [7:0] sec_count;
    logic [7:0] sec_num;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] dev_head;
    logic [7:0] opcode;
    logic [7:0] status;
    logic [7:0] error;
    logic       mult_en;
    logic [7:0] mult_size;
    logic       spin_req;
    logic       if_active;
    logic       asleep;
    logic [7:0] rdata;
    dcm_smart_s smart;
    logic       done;
  } dcm_main_s;

endpackage
`default_nettype wire

// file: rtl/dcm_sync.sv
`timescale 1ns/10ps
`default_nettype none
module dcm_sync
(
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic din,
  output logic      dout
);

  dcm_pkg::dcm_sync_s cur;
  dcm_pkg::dcm_sync_s next_cur;

  // meta stage feeds only the stable stage
  always_comb
  begin
    next_cur.meta   = din;
    next_cur.stable = cur.meta;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign dout = cur.stable;

endmodule // dcm_sync
`default_nettype wire

// file: rtl/dcm_decode.sv
`timescale 1ns/10ps
`default_nettype none
module dcm_decode
(
  input  wire logic [7:0]          opcode,
  input  wire logic [7:0]          feature,
  input  wire logic [7:0]          sec_count,
  input  wire logic [7:0]          cyl_lo,
  input  wire logic [7:0]          cyl_hi,
  output dcm_pkg::dcm_decode_s     dec
);

  logic [7:0] count_less;

  // pure classification of the latched task file
  always_comb
  begin
    count_less      = 8'(sec_count - 8'h01);
    dec.is_set_mult = (opcode == dcm_pkg::OP_SET_MULT);
    // power of two up to the maximum, zero included
    dec.bsize_ok    = ((sec_count & count_less) == 8'h00) &&
                      (sec_count <= dcm_pkg::BSIZE_MAX);
    dec.is_sleep    = (opcode == dcm_pkg::OP_SLEEP) ||
                      (opcode == dcm_pkg::OP_SLEEP_ALT);
    dec.is_smart    = (opcode == dcm_pkg::OP_SMART);
    dec.keys_ok     = (cyl_lo == dcm_pkg::SMART_KEY_LO) &&
                      (cyl_hi == dcm_pkg::SMART_KEY_HI);
    // undefined codes such as the gap at D7 are refused
    unique case (feature)
      dcm_pkg::SUB_READ_ATTR,
      dcm_pkg::SUB_READ_THR,
      dcm_pkg::SUB_AUTOSAVE,
      dcm_pkg::SUB_SAVE_ATTR,
      dcm_pkg::SUB_OFFLINE:    dec.sub_ok = 1'b1;
      dcm_pkg::SUB_READ_LOG,
      dcm_pkg::SUB_WRITE_LOG,
      dcm_pkg::SUB_ENABLE,
      dcm_pkg::SUB_DISABLE,
      dcm_pkg::SUB_STATUS,
      dcm_pkg::SUB_AUTO_OFFLN: dec.sub_ok = 1'b1;
      default:                 dec.sub_ok = 1'b0;
    endcase
  end

endmodule // dcm_decode
`default_nettype wire

// file: rtl/dcm_cmd.sv
// Functional notes
// - opcode C6h written to the command register selects block-size setting.
// - legal nonzero block size enables multi-sector transfers and records sectors per interrupt.
// - illegal block size aborts the command and disables multi-sector transfers.
// - block size comes from sector count; legal values 0,1,2,4,8,16.
// - block size zero is legal and leaves multi-sector transfers disabled.
// - opcode E6h or 99h requests the sleep state.
// - entering sleep stops the spindle and makes the host interface inactive.
// - spindle already stopped means sleep is entered without spin-down.
// - only software or hardware reset wakes the device from sleep.
// - monitoring command B0h is accepted only with the fixed cylinder keys.
// - feature codes D0h to D4h are decoded as monitoring subcommands.
// - feature codes D5h, D6h, D8h to DBh are decoded as subcommands.
`timescale 1ns/10ps
`default_nettype none
module dcm_cmd
(
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  wire logic          soft_reset,
  input  wire logic          spindle_stopped,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [2:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  output logic      [7:0]    reg_rdata,
  output logic      [7:0]    command_status_flags,
  output logic      [7:0]    command_error_flags,
  output logic               multiple_enabled,
  output logic      [7:0]    multiple_block_size,
  output logic               spindle_stop_req,
  output logic               interface_active,
  output logic               asleep,
  output dcm_pkg::dcm_smart_s smart_req,
  output logic               cmd_done
);

  dcm_pkg::dcm_main_s   cur;
  dcm_pkg::dcm_main_s   next_cur;
  dcm_pkg::dcm_decode_s dec;
  logic                 stopped_s;
  logic                 cmd_wr;

  // spindle status arrives from the motor side, outside this clock
  dcm_sync u_stop_sync
  (
    .core_clk (core_clk),
    .reset    (reset),
    .din      (spindle_stopped),
    .dout     (stopped_s)
  );

  // classification works on the latched task file, not the live bus
  dcm_decode u_decode
  (
    .opcode    (cur.opcode),
    .feature   (cur.feature),
    .sec_count (cur.sec_count),
    .cyl_lo    (cur.cyl_lo),
    .cyl_hi    (cur.cyl_hi),
    .dec       (dec)
  );

  // a command is only taken while idle and awake
  assign cmd_wr = reg_wr && (reg_addr == dcm_pkg::ADDR_CMD) &&
                  (cur.st == dcm_pkg::DCM_IDLE) && cur.if_active && !soft_reset;

  // next state of the whole block
  always_comb
  begin
    next_cur             = cur;
    next_cur.smart.valid = 1'b0;
    next_cur.done        = 1'b0;
    next_cur.rdata       = 8'h00;

    // read port is dead while the interface is inactive
    if (reg_rd && cur.if_active)
    begin
      unique case (reg_addr)
        dcm_pkg::ADDR_DATA:    next_cur.rdata = 8'h00;
        dcm_pkg::ADDR_FEATURE: next_cur.rdata = cur.error;
        dcm_pkg::ADDR_SEC_CNT: next_cur.rdata = cur.sec_count;
        dcm_pkg::ADDR_SEC_NUM: next_cur.rdata = cur.sec_num;
        dcm_pkg::ADDR_CYL_LO:  next_cur.rdata = cur.cyl_lo;
        dcm_pkg::ADDR_CYL_HI:  next_cur.rdata = cur.cyl_hi;
        dcm_pkg::ADDR_DEV_HD:  next_cur.rdata = cur.dev_head;
        dcm_pkg::ADDR_CMD:     next_cur.rdata = cur.status;
      endcase
    end

    if (soft_reset)
    begin
      // software reset is the soft wake path out of sleep
      next_cur.st        = dcm_pkg::DCM_IDLE;
      next_cur.status    = dcm_pkg::STATUS_READY;
      next_cur.error     = dcm_pkg::ERROR_NONE;
      next_cur.if_active = 1'b1;
      next_cur.spin_req  = 1'b0;
      next_cur.asleep    = 1'b0;
    end
    else
    begin
      unique case (cur.st)
        dcm_pkg::DCM_IDLE:
        begin
          // task file writes; busy blocks them by leaving this state
          if (reg_wr && cur.if_active)
          begin
            unique case (reg_addr)
              dcm_pkg::ADDR_DATA:    next_cur.st = cur.st;
              dcm_pkg::ADDR_FEATURE: next_cur.feature = reg_wdata;
              dcm_pkg::ADDR_SEC_CNT: next_cur.sec_count = reg_wdata;
              dcm_pkg::ADDR_SEC_NUM: next_cur.sec_num = reg_wdata;
              dcm_pkg::ADDR_CYL_LO:  next_cur.cyl_lo = reg_wdata;
              dcm_pkg::ADDR_CYL_HI:  next_cur.cyl_hi = reg_wdata;
              dcm_pkg::ADDR_DEV_HD:  next_cur.dev_head = reg_wdata;
              dcm_pkg::ADDR_CMD:
              begin
                next_cur.opcode = reg_wdata;
                next_cur.status = dcm_pkg::STATUS_BUSY;
                next_cur.st     = dcm_pkg::DCM_BUSY;
              end
            endcase
          end
        end

        dcm_pkg::DCM_BUSY:
        begin
          // one execute cycle, then completion flags, except sleep with the spindle still turning, which waits for spin-down
          next_cur.done   = 1'b1;
          next_cur.st     = dcm_pkg::DCM_IDLE;
          next_cur.status = dcm_pkg::STATUS_READY;
          next_cur.error  = dcm_pkg::ERROR_NONE;
          if (dec.is_set_mult)
          begin
            if (dec.bsize_ok)
            begin
              // zero is accepted but switches the mode off
              next_cur.mult_en   = (cur.sec_count != 8'h00);
              next_cur.mult_size = cur.sec_count;
            end
            else
            begin
              next_cur.mult_en = 1'b0;
              next_cur.status  = dcm_pkg::STATUS_ABORT;
              next_cur.error   = dcm_pkg::ERROR_ABORT;
            end
          end
          else if (dec.is_sleep)
          begin
            if (stopped_s)
            begin
              // nothing to spin down, drop straight into sleep
              next_cur.st        = dcm_pkg::DCM_ASLEEP;
              next_cur.spin_req  = 1'b1;
              next_cur.if_active = 1'b0;
              next_cur.asleep    = 1'b1;
              next_cur.rdata     = 8'h00; // no read answer survives into sleep
            end
            else
            begin
              next_cur.done     = 1'b0;
              next_cur.status   = dcm_pkg::STATUS_BUSY;
              next_cur.st       = dcm_pkg::DCM_SPIN;
              next_cur.spin_req = 1'b1;
            end
          end
          else if (dec.is_smart && dec.keys_ok && dec.sub_ok)
          begin
            // subcommand body lives outside; hand it the parameters
            next_cur.smart.valid  = 1'b1;
            next_cur.smart.code   = cur.feature;
            next_cur.smart.count  = cur.sec_count;
            next_cur.smart.number = cur.sec_num;
          end
          else
          begin
            // bad keys, bad subcommand or an opcode not handled here
            next_cur.status = dcm_pkg::STATUS_ABORT;
            next_cur.error  = dcm_pkg::ERROR_ABORT;
          end
        end

        dcm_pkg::DCM_SPIN:
        begin
          // no timeout: the motor side must report stop eventually
          if (stopped_s)
          begin
            next_cur.done      = 1'b1;
            next_cur.st        = dcm_pkg::DCM_ASLEEP;
            next_cur.status    = dcm_pkg::STATUS_READY;
            next_cur.error     = dcm_pkg::ERROR_NONE;
            next_cur.if_active = 1'b0;
            next_cur.asleep    = 1'b1;
            next_cur.rdata     = 8'h00; // a late read must not show while asleep
          end
        end

        dcm_pkg::DCM_ASLEEP:
        begin
          // only a reset leaves; every access is ignored
          next_cur.st = dcm_pkg::DCM_ASLEEP;
        end
      endcase
    end
  end

  // state register; hardware reset leaves multi-sector mode disabled
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      cur           <= '0;
      cur.st        <= dcm_pkg::DCM_IDLE;
      cur.status    <= dcm_pkg::STATUS_READY;
      cur.error     <= dcm_pkg::ERROR_NONE;
      cur.if_active <= 1'b1;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // all outputs straight from the state register
  assign reg_rdata            = cur.rdata;
  assign command_status_flags = cur.status;
  assign command_error_flags  = cur.error;
  assign multiple_enabled     = cur.mult_en;
  assign multiple_block_size  = cur.mult_size;
  assign spindle_stop_req     = cur.spin_req;
  assign interface_active     = cur.if_active;
  assign asleep               = cur.asleep;
  assign smart_req            = cur.smart;
  assign cmd_done             = cur.done;

  // checks on command handling
  default clocking dcm_cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  a_setmult_legal_enable: assert property (
    (cur.st == dcm_pkg::DCM_BUSY) && dec.is_set_mult && dec.bsize_ok &&
    (cur.sec_count != 8'h00) && !soft_reset
    |=> cur.mult_en && (cur.mult_size == $past(cur.sec_count)) && cur.done)
    else $error("legal block size did not enable multiple mode");

  a_setmult_bad_abort: assert property (
    (cur.st == dcm_pkg::DCM_BUSY) && dec.is_set_mult && !dec.bsize_ok && !soft_reset
    |=> !cur.mult_en && cur.error[dcm_pkg::ER_ABT] && cur.status[dcm_pkg::ST_ERR])
    else $error("illegal block size not aborted");

  a_bsize_zero_off: assert property (
    (cur.st == dcm_pkg::DCM_BUSY) && dec.is_set_mult &&
    (cur.sec_count == 8'h00) && !soft_reset
    |=> !cur.mult_en && !cur.status[dcm_pkg::ST_ERR])
    else $error("zero block size mishandled");

  a_bsize_value_check: assert property (
    (cmd_wr && (reg_wdata == dcm_pkg::OP_SET_MULT) &&
     !(cur.sec_count inside {8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10}))
    ##1 !soft_reset
    |=> cur.status[dcm_pkg::ST_ERR])
    else $error("block size outside legal set accepted");

  a_sleep_direct_entry: assert property (
    (cur.st == dcm_pkg::DCM_BUSY) && dec.is_sleep && stopped_s && !soft_reset
    |=> (cur.st == dcm_pkg::DCM_ASLEEP) && cur.asleep)
    else $error("sleep with stopped spindle not entered directly");

  a_sleep_spin_down: assert property (
    (cur.st == dcm_pkg::DCM_BUSY) && dec.is_sleep && !stopped_s && !soft_reset
    |=> (cur.st == dcm_pkg::DCM_SPIN) && cur.spin_req && cur.if_active)
    else $error("spin-down not started for sleep");

  a_asleep_inactive: assert property (
    cur.asleep |-> !cur.if_active && cur.spin_req && (cur.rdata == 8'h00))
    else $error("interface active while asleep");

  a_sleep_holds: assert property (
    (cur.st == dcm_pkg::DCM_ASLEEP) && !soft_reset |=> (cur.st == dcm_pkg::DCM_ASLEEP))
    else $error("left sleep without reset");

  a_sleep_wakeup: assert property (
    (cur.st == dcm_pkg::DCM_ASLEEP) && soft_reset
    |=> (cur.st == dcm_pkg::DCM_IDLE) && cur.if_active && !cur.asleep)
    else $error("software reset did not wake device");

  a_smart_key_abort: assert property (
    (cur.st == dcm_pkg::DCM_BUSY) && dec.is_smart && (!dec.keys_ok || !dec.sub_ok) &&
    !soft_reset
    |=> cur.error[dcm_pkg::ER_ABT] && !cur.smart.valid)
    else $error("bad monitoring command not aborted");

  a_smart_issue_code: assert property (
    (cur.st == dcm_pkg::DCM_BUSY) && dec.is_smart && dec.keys_ok && dec.sub_ok &&
    !soft_reset
    |=> cur.smart.valid && (cur.smart.code == $past(cur.feature)) && !cur.error[dcm_pkg::ER_ABT])
    else $error("monitoring subcommand not issued");

  a_done_flags_clean: assert property (
    cur.done |-> !cur.status[dcm_pkg::ST_BSY] && !cur.status[dcm_pkg::ST_DF] &&
    !cur.status[dcm_pkg::ST_COR] && (cur.status[dcm_pkg::ST_ERR] == cur.error[dcm_pkg::ER_ABT]))
    else $error("completion flags wrong");

  c_sleep_via_spin: cover property (
    (cur.st == dcm_pkg::DCM_SPIN) ##1 (cur.st == dcm_pkg::DCM_ASLEEP));
  c_setmult_ok: cover property (cur.done && cur.mult_en);
  c_smart_issued: cover property (cur.smart.valid);
  c_smart_abort: cover property (cur.done && cur.error[dcm_pkg::ER_ABT] && dec.is_smart);

endmodule // dcm_cmd
`default_nettype wire

// file: tb/dcm_host.sv
`timescale 1ns/10ps
`default_nettype none
// host adapter model: one strobe per write or read, changed just after the edge
module dcm_host
(
  input  wire logic       core_clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [2:0]      reg_addr,
  output logic [7:0]      reg_wdata
);
  // quiet bus at time zero
  initial
  begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 3'h0;
    reg_wdata = 8'h00;
  end

  // held across the taking edge, dropped after it; data inverted so stale bytes never match
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1;
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge core_clk);
    #1;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge core_clk);
    #1;
    reg_rd   = 1'b0;
  endtask

  // parameters first, opcode last, so the subcommand is in place when the opcode lands
  task automatic issue(input logic [7:0] f, c, lo, hi, op);
    wr(dcm_pkg::ADDR_FEATURE, f);
    wr(dcm_pkg::ADDR_SEC_CNT, c);
    wr(dcm_pkg::ADDR_SEC_NUM, 8'h5A);
    wr(dcm_pkg::ADDR_CYL_LO, lo);
    wr(dcm_pkg::ADDR_CYL_HI, hi);
    wr(dcm_pkg::ADDR_CMD, op);
  endtask
endmodule // dcm_host
`default_nettype wire

// file: tb/disk_cmd_multiple_sleep_smart_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module disk_cmd_multiple_sleep_smart_tb_top;
  localparam logic [39:0] M_ALL  = 40'hFF_FFFF_FFF8;
  localparam logic [39:0] M_NCD  = 40'hFF_FFFF_00F8;
  localparam logic [39:0] M_NSZ  = 40'hFF_FF00_00F8;
  localparam logic [39:0] M_BYTE = 40'h00_0000_00FF;
  logic                core_clk;
  logic                reset;
  logic                soft_reset;
  logic                spindle_stopped = 1'b0;
  wire logic           reg_wr;
  wire logic           reg_rd;
  wire logic [2:0]     reg_addr;
  wire logic [7:0]     reg_wdata;
  logic [7:0]          reg_rdata;
  logic [7:0]          sts;
  logic [7:0]          err;
  logic                men;
  logic [7:0]          msz;
  logic                stop_req;
  logic                if_act;
  logic                asl;
  dcm_pkg::dcm_smart_s smart;
  logic                cmd_done;
  logic [79:0]         eq[$];
  logic [7:0]          rq[$];
  logic                rd_q = 1'b0;
  logic [7:0]          lag = 8'h00;
  logic [7:0]          n;
  logic [7:0]          f;
  logic [7:0]          m_sz;
  logic                m_en;
  logic                ok;
  logic [39:0]         obs;
  logic [7:0]          sizes[8];
  logic [7:0]          codes[11];
  int                  bad_count;
  int                  tests_run;
  int                  w;
  int                  k;

  dcm_host host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
                 .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  dcm_cmd dut (.core_clk(core_clk), .reset(reset), .soft_reset(soft_reset),
    .spindle_stopped(spindle_stopped), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .command_status_flags(sts), .command_error_flags(err), .multiple_enabled(men),
    .multiple_block_size(msz), .spindle_stop_req(stop_req), .interface_active(if_act),
    .asleep(asl), .smart_req(smart), .cmd_done(cmd_done));

  // free running 100 MHz clock
  always #5 core_clk = ~core_clk;

  task automatic check(input logic [39:0] seen, input logic [39:0] exp, input logic [39:0] msk);
    tests_run++;
    if ((seen & msk) !== (exp & msk))
    begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (bad_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // flags packed as enabled, asleep, interface, stop request, monitoring valid
  task automatic note(input logic [7:0] st, er, cd, input logic [4:0] fl, input logic [39:0] m);
    eq.push_back({st, er, m_sz, cd, fl, 3'h0, m});
  endtask

  task automatic rd_exp(input logic [2:0] a, input logic [7:0] e);
    rq.push_back(e);
    host.rd(a);
  endtask

  // command with busy check and a bounded wait for completion; w counts edges waited
  task automatic run_cmd(input logic [7:0] fe, c, lo, hi, op);
    host.issue(fe, c, lo, hi, op);
    check({32'h0, sts}, {32'h0, dcm_pkg::STATUS_BUSY}, M_BYTE);
    for (w = 0; w < 64 && cmd_done !== 1'b1; w++)
    begin
      @(posedge core_clk);
      #2;
    end
    if (w == 64)
    begin
      bad_count++;
      complete_run();
    end
  endtask

  task automatic pulse(input logic hw);
    @(posedge core_clk);
    #1;
    if (hw)
      reset = 1'b1;
    else
      soft_reset = 1'b1;
    repeat (hw ? 4 : 1) @(posedge core_clk);
    #1;
    reset      = 1'b0;
    soft_reset = 1'b0;
  endtask

  // scoreboard: oldest note against each completion, oldest expected byte against each read answer
  always @(posedge core_clk)
  begin
    rd_q <= reg_rd;
    obs = {sts, err, msz, smart.code, men, asl, if_act, stop_req, smart.valid, 3'h0};
    if (reset === 1'b0 && cmd_done === 1'b1)
    begin
      if (eq.size() == 0)
        check(obs, ~obs, M_ALL);
      else
        check(obs, eq[0][79:40], eq[0][39:0]);
      // parameters handed on with the subcommand: count 01h, number 5Ah as issued
      if (smart.valid === 1'b1)
        check({24'h0, smart.count, smart.number}, 40'h00_0000_015A, 40'h00_0000_FFFF);
      if (eq.size() != 0)
        eq.pop_front();
    end
    if (rd_q === 1'b1 && rq.size() != 0)
      check({32'h0, reg_rdata}, {32'h0, rq.pop_front()}, M_BYTE);
  end

  // motor: spindle stops a few cycles after the stop request rises
  always @(posedge core_clk)
  begin
    lag <= (stop_req === 1'b1) ? lag + 8'h01 : 8'h00;
    if (lag == 8'h05)
      spindle_stopped <= 1'b1;
  end

  // hang guard
  initial
  begin
    #1000000;
    bad_count++;
    complete_run();
  end

  initial
  begin
    core_clk = 1'b0;
    reset = 1'b1;
    soft_reset = 1'b0;
    bad_count = 0;
    tests_run = 0;
    m_en = 1'b0;
    m_sz = 8'h00;
    sizes = '{8'h08, 8'h03, 8'h10, 8'h00, 8'h11, 8'h01, 8'h02, 8'h04};
    codes = '{8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6, 8'hD8, 8'hD9, 8'hDA, 8'hDB};
    w = $urandom(32'hB5316C4B);
    repeat (4) @(posedge core_clk);
    #1;
    reset = 1'b0;
    // block sizes: random bytes first, then every legal value and near misses
    for (k = 0; k < 12; k++)
    begin
      n = (k < 4) ? 8'($urandom % 256) : sizes[k - 4];
      ok = (n inside {8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10});
      m_en = ok && (n != 8'h00);
      m_sz = ok ? n : m_sz;
      note(ok ? 8'h50 : 8'h51, ok ? 8'h00 : 8'h04, 8'h00, {m_en, 4'b0100}, ok ? M_NCD : M_NSZ);
      run_cmd(8'h00, n, 8'h00, 8'h00, dcm_pkg::OP_SET_MULT);
      if (k == 5)
      begin
        rd_exp(dcm_pkg::ADDR_FEATURE, 8'h04);
        rd_exp(dcm_pkg::ADDR_CMD, 8'h51);
        rd_exp(dcm_pkg::ADDR_DATA, 8'h00);
      end
    end
    // every subcommand, one undefined code, then each key broken in turn
    for (k = 0; k < 14; k++)
    begin
      ok = (k < 11);
      f = ok ? codes[k] : (k == 11 ? 8'hD7 : dcm_pkg::SUB_ENABLE);
      note(ok ? 8'h50 : 8'h51, ok ? 8'h00 : 8'h04, f, {m_en, 3'b010, ok}, ok ? M_ALL : M_NCD);
      run_cmd(f, 8'h01, (k == 12) ? 8'h4E : dcm_pkg::SMART_KEY_LO,
              (k == 13) ? 8'hC3 : dcm_pkg::SMART_KEY_HI, dcm_pkg::OP_SMART);
    end
    // sleep while spinning: completes only after the spindle reports stopped
    note(8'h50, 8'h00, 8'h00, {m_en, 4'b1010}, M_NCD);
    run_cmd(8'h00, 8'h00, 8'h00, 8'h00, dcm_pkg::OP_SLEEP);
    rd_exp(dcm_pkg::ADDR_CMD, 8'h00);
    host.issue(8'h00, 8'h02, 8'h00, 8'h00, dcm_pkg::OP_SET_MULT);
    repeat (10) @(posedge core_clk);
    check({39'h0, asl}, 40'h1, M_BYTE);
    pulse(1'b0);
    rd_exp(dcm_pkg::ADDR_CMD, 8'h50);
    // spindle already stopped: sleep is reached with no spin-down wait
    note(8'h50, 8'h00, 8'h00, {m_en, 4'b1010}, M_NCD);
    run_cmd(8'h00, 8'h00, 8'h00, 8'h00, dcm_pkg::OP_SLEEP_ALT);
    check(40'(w), 40'h1, M_ALL);
    pulse(1'b1);
    m_en = 1'b0;
    m_sz = 8'h00;
    rd_exp(dcm_pkg::ADDR_CMD, 8'h50);
    check({32'h0, if_act, asl, men, 5'h0}, 40'h80, M_BYTE);
    repeat (4) @(posedge core_clk);
    complete_run();
  end
endmodule // disk_cmd_multiple_sleep_smart_tb_top
`default_nettype wire
